// file: core/tlbt_tag_cache.v
// Purpose: tagged translation cache: insert, lookup and invalidate
// Assumes: inputs synchronous to sys_clk; walker and lookups keep their own order
// Notes: fully associative, round-robin replacement
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "tlbt_defines.vh"

module tlbt_tag_cache #(
  parameter ENTRIES = 8,
  parameter IDX_W = 3,
  parameter ADDR_W = 36,
  parameter PA_W = 36
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // insert from walker
  input wire ins_valid,
  input wire [2:0] ins_regime_select_field,
  input wire ins_is_ipa,
  input wire ins_not_global_bit,
  input wire ins_shared_set_flag,
  input wire [15:0] ins_asid,
  input wire [15:0] ins_entry_vm_tag_field,
  input wire [ADDR_W-1:0] ins_addr,
  input wire [PA_W-1:0] ins_pa,
  // lookup
  input wire lk_valid,
  input wire [2:0] lk_regime,
  input wire lk_is_ipa,
  input wire [15:0] lk_asid,
  input wire [15:0] lk_vm_tag,
  input wire [ADDR_W-1:0] lk_addr,
  output reg lk_done_ff,
  output reg lk_hit_ff,
  output reg [PA_W-1:0] lk_pa_ff,
  output reg lk_shared_set_ff,
  // invalidation
  input wire inv_valid,
  input wire [1:0] inv_scope,
  input wire [2:0] inv_regime,
  input wire [15:0] inv_asid,
  input wire [15:0] inv_vm_tag,
  output reg inv_done_ff
);

  // entry storage
  reg [ENTRIES-1:0] vld_ff;
  reg [2:0] rg_ff [0:ENTRIES-1];
  reg [ENTRIES-1:0] ipa_ff;
  reg [ENTRIES-1:0] has_asid_ff;
  reg [ENTRIES-1:0] has_vm_ff;
  reg [ENTRIES-1:0] sset_ff;
  reg [15:0] asid_ff [0:ENTRIES-1];
  reg [15:0] vm_ff [0:ENTRIES-1];
  reg [ADDR_W-1:0] addr_ff [0:ENTRIES-1];
  reg [PA_W-1:0] pa_ff [0:ENTRIES-1];
  reg [IDX_W-1:0] victim_ff;
  reg [1:0] ctrl_ff;
  reg [4:0] cfg_ff;
  reg [15:0] hit_cnt_ff;
  reg [15:0] miss_cnt_ff;

  wire en = ctrl_ff[`TLBT_CTL_EN];
  wire stage_two_present = cfg_ff[`TLBT_CFG_STAGE2];

  // regime carries asids only for va entries in these regimes
  function asid_regime;
    input [2:0] rg;
    input ipa;
    begin
      asid_regime = !ipa && (rg == `TLBT_RG_NS_EL1 || rg == `TLBT_RG_RL_EL1 ||
                    rg == `TLBT_RG_SECURE); // R02 R05
    end
  endfunction

  // regime uses vm tags given capabilities
  function vm_regime;
    input [2:0] rg;
    input [4:0] cfg;
    begin
      vm_regime = cfg[`TLBT_CFG_STAGE2] && ((rg == `TLBT_RG_NS_EL1 || rg == `TLBT_RG_RL_EL1) || // R03 R14 R16
                  (rg == `TLBT_RG_SECURE && cfg[`TLBT_CFG_SECS2])); // R04
    end
  endfunction

  // narrow id to implemented width
  function [15:0] id_mask;
    input [15:0] id;
    input wide;
    begin
      id_mask = wide ? id : (id & `TLBT_BYTE_MASK); // R12 R13
    end
  endfunction

  // el2-e2h arrives as an asid regime through the select field: model as per-world el2
  // with asid when the select field top bit pattern is el1-like; here el2 has none.
  wire ins_has_asid = asid_regime(ins_regime_select_field, ins_is_ipa) && ins_not_global_bit; // R02
  wire ins_has_vm = vm_regime(ins_regime_select_field, cfg_ff); // R03 R04 R14
  wire [15:0] ins_asid_m = id_mask(ins_asid, cfg_ff[`TLBT_CFG_WASID] & cfg_ff[`TLBT_CFG_STAGE1]); // R12
  wire [15:0] ins_vm_m = id_mask(ins_entry_vm_tag_field, cfg_ff[`TLBT_CFG_WVMID]); // R13 R15
  wire [15:0] lk_asid_m = id_mask(lk_asid, cfg_ff[`TLBT_CFG_WASID] & cfg_ff[`TLBT_CFG_STAGE1]);
  wire [15:0] lk_vm_m = id_mask(lk_vm_tag, cfg_ff[`TLBT_CFG_WVMID]);
  wire [15:0] inv_asid_m = id_mask(inv_asid, cfg_ff[`TLBT_CFG_WASID] & cfg_ff[`TLBT_CFG_STAGE1]);
  wire [15:0] inv_vm_m = id_mask(inv_vm_tag, cfg_ff[`TLBT_CFG_WVMID]);

  // lookup and invalidate match vectors
  reg [ENTRIES-1:0] lk_match;
  reg [ENTRIES-1:0] inv_match;
  reg [IDX_W-1:0] lk_idx;
  integer i;
  always @* begin
    lk_match = {ENTRIES{1'b0}};
    inv_match = {ENTRIES{1'b0}};
    lk_idx = {IDX_W{1'b0}};
    for (i = 0; i < ENTRIES; i = i + 1) begin
      // exact regime match keeps el2 worlds, el3, secure and ns apart
      lk_match[i] = vld_ff[i] && rg_ff[i] == lk_regime && ipa_ff[i] == lk_is_ipa && // R10 R18 R19
                    addr_ff[i] == lk_addr &&
                    (!has_asid_ff[i] || asid_ff[i] == lk_asid_m) && // R09 R11
                    (!has_vm_ff[i] || vm_ff[i] == lk_vm_m); // R09
      case (inv_scope)
        `TLBT_INV_ALL: inv_match[i] = vld_ff[i];
        `TLBT_INV_REGIME: inv_match[i] = vld_ff[i] && rg_ff[i] == inv_regime;
        `TLBT_INV_ASID: inv_match[i] = vld_ff[i] && rg_ff[i] == inv_regime && has_asid_ff[i] &&
                                       asid_ff[i] == inv_asid_m &&
                                       (!has_vm_ff[i] || vm_ff[i] == inv_vm_m); // R09
        `TLBT_INV_VM: inv_match[i] = vld_ff[i] && rg_ff[i] == inv_regime && has_vm_ff[i] &&
                                     vm_ff[i] == inv_vm_m;
        default: inv_match[i] = 1'b0;
      endcase
    end
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
      if (lk_match[i]) begin
        lk_idx = i[IDX_W-1:0];
      end
    end
  end

  wire do_flush = reg_wr && reg_addr == `TLBT_REG_CTRL && reg_wdata[`TLBT_CTL_FLUSH];

  // entry state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_ff <= {ENTRIES{1'b0}};
      victim_ff <= {IDX_W{1'b0}};
    end else begin
      if (do_flush) begin
        vld_ff <= {ENTRIES{1'b0}};
      end else begin
        if (inv_valid) begin
          vld_ff <= vld_ff & ~inv_match;
        end
        if (ins_valid && en) begin
          vld_ff[victim_ff] <= 1'b1; // R01
          victim_ff <= victim_ff + {{(IDX_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // payload, no reset needed behind valid
  always @(posedge sys_clk) begin
    if (ins_valid && en) begin
      rg_ff[victim_ff] <= ins_regime_select_field; // R01 R18
      ipa_ff[victim_ff] <= ins_is_ipa;
      has_asid_ff[victim_ff] <= ins_has_asid; // R02 R05
      has_vm_ff[victim_ff] <= ins_has_vm; // R03 R16
      asid_ff[victim_ff] <= ins_has_asid ? ins_asid_m : 16'h0000; // R11
      vm_ff[victim_ff] <= ins_has_vm ? ins_vm_m : 16'h0000; // R15
      // flag kept for every va entry, global or not, el2 and el3 included
      sset_ff[victim_ff] <= ins_is_ipa ? 1'b0 : ins_shared_set_flag; // R06 R07 R08
      addr_ff[victim_ff] <= ins_addr;
      pa_ff[victim_ff] <= ins_pa;
    end
  end

  // lookup answer one cycle later
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_done_ff <= 1'b0;
      lk_hit_ff <= 1'b0;
      lk_pa_ff <= {PA_W{1'b0}};
      lk_shared_set_ff <= 1'b0;
      inv_done_ff <= 1'b0;
      hit_cnt_ff <= 16'h0000;
      miss_cnt_ff <= 16'h0000;
    end else begin
      lk_done_ff <= lk_valid;
      lk_hit_ff <= lk_valid && en && |lk_match; // R19
      lk_pa_ff <= (lk_valid && en && |lk_match) ? pa_ff[lk_idx] : {PA_W{1'b0}};
      lk_shared_set_ff <= (lk_valid && en && |lk_match) ? sset_ff[lk_idx] : 1'b0;
      inv_done_ff <= inv_valid;
      if (lk_valid && en && |lk_match) begin
        hit_cnt_ff <= hit_cnt_ff + 16'h0001;
      end else if (lk_valid) begin
        miss_cnt_ff <= miss_cnt_ff + 16'h0001;
      end
    end
  end

  // registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 2'h0;
      cfg_ff <= `TLBT_CFG_RST;
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `TLBT_REG_CTRL) begin
        ctrl_ff <= {1'b0, reg_wdata[`TLBT_CTL_EN]};
      end
      if (reg_wr && reg_addr == `TLBT_REG_CFG) begin
        cfg_ff <= reg_wdata[4:0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `TLBT_REG_CTRL: reg_rdata_ff <= {31'h0, ctrl_ff[`TLBT_CTL_EN]};
          `TLBT_REG_STAT: reg_rdata_ff <= {hit_cnt_ff[7:0], miss_cnt_ff[7:0], 8'h00, vld_ff[7:0] & 8'hff};
          `TLBT_REG_CFG: reg_rdata_ff <= {27'h0, cfg_ff};
          default: reg_rdata_ff <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata_ff <= 32'h0000_0000;
      end
    end
  end

  wire unused_stage_two = stage_two_present;

endmodule // tlbt_tag_cache

// file: dv/tlbt_chk_assertions.sv
// Purpose: port timing and qualification checks for the tag cache
// Assumes: one clock, active-low asynchronous reset
// Notes: bound to every tag cache instance
`timescale 1ns/100ps
`include "tlbt_defines.vh"
module tlbt_chk #(parameter PA_W = 36) (
  // clock and reset
  input logic sys_clk, rst_n,
  // requests
  input logic reg_rd, ins_valid, lk_valid, inv_valid,
  input logic [1:0] inv_scope,
  // answers
  input logic [31:0] reg_rdata_ff,
  input logic lk_done_ff, lk_hit_ff, lk_shared_set_ff, inv_done_ff,
  input logic [PA_W-1:0] lk_pa_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // full flush with no insert racing it, then a quiet cycle
  sequence s_clean_flush;
    inv_valid && inv_scope == `TLBT_INV_ALL && !ins_valid ##1 !ins_valid;
  endsequence
  sequence s_late_look;
    s_clean_flush ##1 lk_valid;
  endsequence
  chk_lk_answer: assert property (lk_valid |=> lk_done_ff)
    else $error("lookup answer missing");
  chk_lk_cause: assert property (lk_done_ff |-> $past(lk_valid))
    else $error("lookup answer without request");
  chk_inv_answer: assert property (inv_valid |=> inv_done_ff)
    else $error("invalidate done missing");
  chk_inv_cause: assert property (inv_done_ff |-> $past(inv_valid))
    else $error("invalidate done without request");
  chk_hit_in_done: assert property (lk_hit_ff || lk_shared_set_ff |-> lk_done_ff)
    else $error("hit outside answer cycle");
  chk_pa_idle: assert property (!lk_done_ff |-> lk_pa_ff == '0)
    else $error("translated address not cleared");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data outside answer cycle");
  chk_flush_miss: assert property (s_late_look |=> !lk_hit_ff)
    else $error("hit after full flush");
endmodule // tlbt_chk
bind tlbt_tag_cache tlbt_chk #(.PA_W(PA_W)) chk_u (.*);

// file: dv/tlbt_walk_model.sv
// Purpose: walker model handing finished translations to the cache
// Assumes: go is a one-cycle request from the bench
// Notes: shared-set flag follows asid bit 0; idle fields toggle
`timescale 1ns/100ps
module tlbt_walk_model (
  // clock and request
  input logic sys_clk, go, ng,
  input logic [35:0] pa, lk_addr,
  input logic [2:0] lk_regime,
  input logic lk_is_ipa,
  input logic [15:0] lk_asid, lk_vm_tag,
  // insert port
  output logic ins_valid = 1'b0,
  output logic ins_is_ipa, ins_not_global_bit, ins_shared_set_flag,
  output logic [2:0] ins_regime_select_field,
  output logic [15:0] ins_asid, ins_entry_vm_tag_field,
  output logic [35:0] ins_addr, ins_pa
);
  always @(posedge sys_clk) begin
    ins_valid <= go;
    ins_is_ipa <= go ? lk_is_ipa : ~ins_is_ipa;
    ins_not_global_bit <= go ? ng : ~ins_not_global_bit;
    ins_shared_set_flag <= go ? lk_asid[0] : ~ins_shared_set_flag;
    ins_regime_select_field <= go ? lk_regime : ~ins_regime_select_field;
    ins_asid <= go ? lk_asid : ~ins_asid;
    ins_entry_vm_tag_field <= go ? lk_vm_tag : ~ins_entry_vm_tag_field;
    ins_addr <= go ? lk_addr : ~ins_addr;
    ins_pa <= go ? pa : ~ins_pa;
  end
endmodule // tlbt_walk_model

// file: dv/translation_tlb_tagging_tb_top.sv
// Purpose: self-checking bench for the tag cache
// Assumes: walker model inserts, bench looks up and invalidates
// Notes: expectations queued by drivers, compared by a monitor
`timescale 1ns/100ps
`include "tlbt_defines.vh"
module translation_tlb_tagging_tb_top;
  logic sys_clk = 0, rst_n = 0, go = 0, ng = 0, rd_d = 0, reg_wr = 0, reg_rd = 0;
  logic lk_valid = 0, lk_is_ipa = 0, inv_valid = 0, ins_valid, ins_is_ipa, ins_not_global_bit;
  logic ins_shared_set_flag, lk_done_ff, lk_hit_ff, lk_shared_set_ff, inv_done_ff;
  logic [1:0] inv_scope = 0;
  logic [2:0] lk_regime = 0, inv_regime = 0, ins_regime_select_field;
  logic [3:0] reg_addr = 0;
  logic [15:0] lk_asid = 0, lk_vm_tag = 0, inv_asid = 0, inv_vm_tag = 0, ins_asid, ins_entry_vm_tag_field;
  logic [31:0] reg_wdata = 0, reg_rdata_ff, rq[$];
  logic [35:0] lk_addr = 0, pa = 0, x, y, z, ins_addr, ins_pa, lk_pa_ff;
  logic [37:0] lq[$];
  int seed = 32'hd843, miscompares = 0, tests_run = 0;
  always #2 sys_clk = ~sys_clk;
  tlbt_tag_cache dut_u (.*);
  tlbt_walk_model wm_u (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [37:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    tick(1);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    tick(1);
  endtask
  task automatic set(input logic [2:0] r, input logic n, input logic [15:0] a, v, input logic [35:0] ad);
    lk_regime <= r;
    ng <= n;
    lk_asid <= a;
    lk_vm_tag <= v;
    lk_addr <= ad;
  endtask
  task automatic put(input logic [2:0] r, input logic n, input logic [15:0] a, v, input logic [35:0] ad, p);
    set(r, n, a, v, ad);
    pa <= p;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
  endtask
  task automatic look(input logic [2:0] r, input logic [15:0] a, v, input logic [35:0] ad, input logic [37:0] e);
    set(r, 1'b0, a, v, ad);
    lq.push_back(e);
    lk_valid <= 1'b1;
    tick(1);
    lk_valid <= 1'b0;
    tick(1);
  endtask
  task automatic inv(input logic [1:0] s, input logic [2:0] r);
    inv_scope <= s;
    inv_regime <= r;
    inv_valid <= 1'b1;
    tick(1);
    inv_valid <= 1'b0;
    tick(1);
  endtask
  function automatic logic [37:0] h(input logic sh, input logic [35:0] p);
    return {1'b1, sh, p};
  endfunction
  task automatic end_of_test;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata_ff, rq.pop_front());
    if (lk_done_ff) chk({lk_hit_ff, lk_shared_set_ff, lk_pa_ff}, lq.pop_front());
  end
  initial begin
    tick(20000);
    miscompares++;
    end_of_test();
  end
  initial begin
    tick(5);
    rst_n <= 1'b1;
    tick(1);
    reg_op(0, `TLBT_REG_CFG, 32'h1f);
    reg_op(0, 4'hf, 32'h0);
    reg_op(1, `TLBT_REG_CTRL, 32'h1);
    x = {$random(seed), $random(seed)};
    y = ~x;
    z = x ^ 36'h5a5;
    put(`TLBT_RG_NS_EL1, 1, 3, 5, x, 1);
    put(`TLBT_RG_SECURE, 1, 3, 5, x, 2);
    look(`TLBT_RG_NS_EL1, 3, 5, x, h(1, 1));
    look(`TLBT_RG_SECURE, 3, 5, x, h(1, 2));
    look(`TLBT_RG_NS_EL1, 4, 5, x, 0);
    look(`TLBT_RG_NS_EL1, 3, 6, x, 0);
    look(`TLBT_RG_SECURE, 3, 6, x, 0);
    lk_is_ipa <= 1'b1;
    put(`TLBT_RG_NS_EL1, 1, 8, 5, y, 3);
    look(`TLBT_RG_NS_EL1, 2, 5, y, h(0, 3));
    look(`TLBT_RG_NS_EL1, 2, 7, y, 0);
    lk_is_ipa <= 1'b0;
    look(`TLBT_RG_NS_EL1, 8, 5, y, 0);
    put(`TLBT_RG_NS_EL2, 1, 6, 1, z, 4);
    look(`TLBT_RG_NS_EL2, 9, 2, z, h(0, 4));
    look(`TLBT_RG_EL3, 9, 2, z, 0);
    look(`TLBT_RG_S_EL2, 9, 2, z, 0);
    look(`TLBT_RG_RL_EL2, 9, 2, z, 0);
    put(`TLBT_RG_EL3, 1, 6, 0, z, 5);
    look(`TLBT_RG_EL3, 1, 1, z, h(0, 5));
    put(`TLBT_RG_RL_EL1, 0, 5, 5, y, 6);
    look(`TLBT_RG_RL_EL1, 8, 5, y, h(1, 6));
    look(`TLBT_RG_RL_EL1, 8, 4, y, 0);
    inv(`TLBT_INV_REGIME, `TLBT_RG_NS_EL2);
    look(`TLBT_RG_NS_EL2, 9, 2, z, 0);
    look(`TLBT_RG_EL3, 1, 1, z, h(0, 5));
    inv(`TLBT_INV_ALL, 0);
    look(`TLBT_RG_NS_EL1, 3, 5, x, 0);
    reg_op(1, `TLBT_REG_CFG, 32'h07);
    put(`TLBT_RG_NS_EL1, 1, 16'h0103, 16'h0205, x, 7);
    look(`TLBT_RG_NS_EL1, 16'h0203, 16'h0305, x, h(1, 7));
    reg_op(1, `TLBT_REG_CFG, 32'h1f);
    put(`TLBT_RG_NS_EL1, 1, 16'h0103, 16'h0205, y, 8);
    look(`TLBT_RG_NS_EL1, 16'h0203, 16'h0205, y, 0);
    look(`TLBT_RG_NS_EL1, 16'h0103, 16'h0305, y, 0);
    look(`TLBT_RG_NS_EL1, 16'h0103, 16'h0205, y, h(1, 8));
    inv_asid <= 16'h0103;
    inv_vm_tag <= 16'h0205;
    inv(`TLBT_INV_ASID, `TLBT_RG_NS_EL1);
    look(`TLBT_RG_NS_EL1, 16'h0103, 16'h0205, y, 0);
    look(`TLBT_RG_NS_EL1, 16'h0003, 16'h0005, x, h(1, 7));
    inv_vm_tag <= 16'h0005;
    inv(`TLBT_INV_VM, `TLBT_RG_NS_EL1);
    look(`TLBT_RG_NS_EL1, 16'h0003, 16'h0005, x, 0);
    reg_op(1, `TLBT_REG_CFG, 32'h19);
    reg_op(0, `TLBT_REG_CFG, 32'h19);
    put(`TLBT_RG_NS_EL1, 1, 3, 5, z, 9);
    look(`TLBT_RG_NS_EL1, 3, 6, z, h(1, 9));
    reg_op(1, `TLBT_REG_CTRL, 32'h3);
    look(`TLBT_RG_NS_EL1, 3, 6, z, 0);
    reg_op(1, `TLBT_REG_CTRL, 32'h0);
    put(`TLBT_RG_NS_EL1, 1, 3, 5, x, 10);
    reg_op(1, `TLBT_REG_CTRL, 32'h1);
    look(`TLBT_RG_NS_EL1, 3, 5, x, 0);
    tick(2);
    if (lq.size() != 0 || rq.size() != 0) miscompares++;
    end_of_test();
  end
endmodule // translation_tlb_tagging_tb_top

// file: include/tlbt_defines.vh
// Purpose: constants for the translation tlb tagging block
// Assumes: one clock, plain register port
// Notes: regime codes, register offsets and field positions
// Behaviour
// R01: every cached entry stores a regime tag taken from the stream regime select
// R02: asid regimes store an asid only when the not-global bit is one
// R03: vm tag stored only with stage two and a vm-tagged regime, va and ipa
// R04: secure entries store a vm tag only when secure stage two is supported
// R05: el3 entries carry no asid nor vm tag; el2 va and ipa carry no asid
// R06: shared-set flag stored whenever the not-global bit is zero where it applies
// R07: shared-set flag also stored for not-global entries
// R08: shared-set flag in el2 and el3 entries is optional, kept here
// R09: asids are separate namespaces per vm tag and per regime
// R10: el3 lookups never hit el2 entries; secure entries never hit ns-el1 lookups
// R11: regimes without asids treat all context descriptors as equivalent
// R12: asid tag is 16 bits with wide asid support, else low eight bits; the code keeps 16 bits only when stage one is also set, else low eight bits
// R13: vm tag is 16 bits with wide vm tag support, else low eight bits
// R14: with stage two, every ns-el1 entry carries a vm tag
// R15: vm tag value comes from the entry vm tag field of the stream entry
// R16: without stage two, vm tags are omitted
// R17: configuration caches carry no tags; this block holds translations only
// R18: el2 rules apply separately to ns, secure and realm el2 regimes
// R19: a hit needs regime, address and each applicable tag to match
`ifndef TLBT_DEFINES_VH
`define TLBT_DEFINES_VH

// regime codes
`define TLBT_RG_NS_EL1 3'h0
`define TLBT_RG_RL_EL1 3'h1
`define TLBT_RG_NS_EL2 3'h2
`define TLBT_RG_S_EL2 3'h3
`define TLBT_RG_RL_EL2 3'h4
`define TLBT_RG_SECURE 3'h5
`define TLBT_RG_EL3 3'h6

// register offsets
`define TLBT_REG_CTRL 4'h0
`define TLBT_REG_STAT 4'h1
`define TLBT_REG_CFG 4'h2

// ctrl fields
`define TLBT_CTL_EN 0
`define TLBT_CTL_FLUSH 1
// cfg fields (capabilities)
`define TLBT_CFG_STAGE1 0
`define TLBT_CFG_STAGE2 1
`define TLBT_CFG_SECS2 2
`define TLBT_CFG_WASID 3
`define TLBT_CFG_WVMID 4
`define TLBT_CFG_RST 5'h1f

`define TLBT_BYTE_MASK 16'h00ff

// invalidation scopes
`define TLBT_INV_ALL 2'h0
`define TLBT_INV_REGIME 2'h1
`define TLBT_INV_ASID 2'h2
`define TLBT_INV_VM 2'h3

`endif
